/* design/rmxu_pkg.sv */
/*
 * Constants, enumerations and carrier types of the register move and
 * extend unit. Assumes a 32-bit classic Wishbone register bus with an
 * 8-bit byte address.
 */
package rmxu_pkg;

	// Byte addresses of the software visible registers.
	localparam logic [7:0] RMXU_ADR_CMD    = 8'h00;
	localparam logic [7:0] RMXU_ADR_STATUS = 8'h04;
	localparam logic [7:0] RMXU_ADR_A0X    = 8'h08;
	localparam logic [7:0] RMXU_ADR_A0W    = 8'h0c;
	localparam logic [7:0] RMXU_ADR_A1X    = 8'h10;
	localparam logic [7:0] RMXU_ADR_A1W    = 8'h14;
	// The sixteen general registers sit at 0x40 + 4 * index.
	localparam logic [1:0] RMXU_GPR_PAGE   = 2'h1;

	// Reset values.
	localparam logic [31:0] RMXU_RST_WORD  = 32'h0000_0000;
	localparam logic [7:0]  RMXU_RST_EXT   = 8'h00;
	localparam logic [15:0] RMXU_RST_CMD   = 16'h0000;
	localparam logic [6:0]  RMXU_RST_FLAGS = 7'h00;

	// Positions inside the 40-bit extraction path.
	localparam int RMXU_RND_POS = 16;

	// Operations launched by a write of the command register.
	typedef enum logic [3:0] {
		RMXU_OP_NOP      = 4'h0,
		RMXU_OP_MOV_SET  = 4'h1,
		RMXU_OP_MOV_CLR  = 4'h2,
		RMXU_OP_ZEXT     = 4'h3,
		RMXU_OP_SEXT     = 4'h4,
		RMXU_OP_EXT_WR   = 4'h5,
		RMXU_OP_EXT_RD   = 4'h6,
		RMXU_OP_ACC_LO   = 4'h7,
		RMXU_OP_ACC_HI   = 4'h8,
		RMXU_OP_XTR_LO   = 4'h9,
		RMXU_OP_XTR_HI   = 4'ha,
		RMXU_OP_XTR_BOTH = 4'hb
	} rmxu_op_e;

	// Formatting choices of the accumulator extraction.
	typedef enum logic [2:0] {
		RMXU_FMT_FRAC  = 3'h0,
		RMXU_FMT_UFRAC = 3'h1,
		RMXU_FMT_SINT  = 3'h2,
		RMXU_FMT_UINT  = 3'h3,
		RMXU_FMT_TRUNC = 3'h4,
		RMXU_FMT_SRND  = 3'h5,
		RMXU_FMT_SSINT = 3'h6,
		RMXU_FMT_HIGH  = 3'h7
	} rmxu_fmt_e;

	// Command word, low 16 bits of the command register.
	typedef struct packed {
		rmxu_fmt_e  fmt;
		logic       acc_sel;
		logic [3:0] src;
		logic [3:0] dst;
		rmxu_op_e   op;
	} rmxu_cmd_s;

	// Arithmetic status word, low 7 bits of the status register.
	typedef struct packed {
		logic rounding_select_bit;
		logic sticky_overflow_flag;
		logic overflow_flag;
		logic carry_flag;
		logic negative_flag;
		logic zero_flag;
		logic condition_flag;
	} rmxu_flags_s;

endpackage : rmxu_pkg

/* design/rmxu_top.sv */
/*
 * Register move and extend unit: conditional moves, half to word
 * extension, accumulator half moves and formatted accumulator
 * extraction, all reached as a classic Wishbone slave.
 * Assumes the bus master runs on clk; no input needs synchronising.
 */
// Added by the designer: register access over Wishbone and the placing of the registers.
// Functional notes
// - move on set flag when flag is one
// - move on clear flag when flag is zero
// - conditional move reaches data and pointer registers
// - zero extend low half, upper half zero
// - zero extend sets zero, clears three flags
// - sign extend low half from bit fifteen
// - sign extend updates zero, negative; clears carry, overflow
// - extension register keeps only low byte
// - extension read sign extends into half
// - accumulator low half write keeps rest
// - accumulator high half write keeps rest
// - half moves touch only named half
// - dual extraction targets one data register
// - extraction saturates sixteen bits, rounds optionally
// - fractional extraction takes accumulator high halves
// - signed integer extraction takes low halves
// - eight formatting choices for extraction
// - rounding select picks biased or unbiased
// - integer and truncate choices ignore rounding select
// - default rounds at bit sixteen, saturates
// - integer choices saturate low sixteen bits
// - rounding happens before saturation
// - extraction sets overflow and sticky overflow
`timescale 1ns/1ps

module rmxu_top (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Half an LSB of the extracted half word sits one place below the cut.
	localparam int RMXU_POS_M1 = rmxu_pkg::RMXU_RND_POS - 1;

	// Byte lane merge of a bus write into a stored word.
	function automatic logic [31:0] rmxu_merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0]  sel
	);
		logic [31:0] res;
		begin
			res = old_w;
			for (int i = 0; i < 4; i++)
			begin
				if (sel[i])
				begin
					res[8*i +: 8] = new_w[8*i +: 8];
				end
			end
			return res;
		end
	endfunction : rmxu_merge

	// Formatted extraction: returns {overflow, result}. The accumulator is
	// only read here, so no option can alter it.
	function automatic logic [16:0] rmxu_extract(
		input logic [39:0] acc,
		input rmxu_pkg::rmxu_fmt_e fmt,
		input logic        rsel
	);
		logic signed [41:0] v;
		logic signed [41:0] q;
		logic               rnd_en;
		logic               inc;
		logic               uns;
		logic               ovf;
		logic [15:0]        res;
		begin
			v = {{2{acc[39]}}, acc};
			// Scaled choices double the value before anything else.
			if (fmt == rmxu_pkg::RMXU_FMT_SRND || fmt == rmxu_pkg::RMXU_FMT_SSINT)
			begin
				v = v <<< 1;
			end
			// Only these choices consult the rounding select bit.
			rnd_en = (fmt == rmxu_pkg::RMXU_FMT_FRAC) || (fmt == rmxu_pkg::RMXU_FMT_UFRAC)
				|| (fmt == rmxu_pkg::RMXU_FMT_SRND) || (fmt == rmxu_pkg::RMXU_FMT_HIGH);
			uns = (fmt == rmxu_pkg::RMXU_FMT_UFRAC) || (fmt == rmxu_pkg::RMXU_FMT_UINT);
			if (fmt == rmxu_pkg::RMXU_FMT_SINT || fmt == rmxu_pkg::RMXU_FMT_UINT
				|| fmt == rmxu_pkg::RMXU_FMT_SSINT)
			begin
				q = v;
			end
			else
			begin
				// Biased rounding adds half an LSB; unbiased rounds an exact
				// half toward even. Truncation simply drops the low bits.
				inc = rnd_en & v[RMXU_POS_M1] & (rsel | (v[15:0] != 16'h8000)
					| v[rmxu_pkg::RMXU_RND_POS]);
				q = v >>> rmxu_pkg::RMXU_RND_POS;
				q = q + {41'h0, inc};
			end
			// Saturate the rounded value to sixteen bits.
			ovf = 1'b0;
			res = q[15:0];
			if (uns)
			begin
				if (q < 42'sh0)
				begin
					res = 16'h0000;
					ovf = 1'b1;
				end
				else if (q > 42'sh0ffff)
				begin
					res = 16'hffff;
					ovf = 1'b1;
				end
			end
			else if (q > 42'sh07fff)
			begin
				res = 16'h7fff;
				ovf = 1'b1;
			end
			else if (q < -42'sh08000)
			begin
				res = 16'h8000;
				ovf = 1'b1;
			end
			return {ovf, res};
		end
	endfunction : rmxu_extract

	////////////////////////////////////////////////////////////////////////
	// State.

	logic [31:0]           gpr_r     [16];
	logic [31:0]           gpr_nxt   [16];
	logic [7:0]            acc_x_r   [2];
	logic [7:0]            acc_x_nxt [2];
	logic [31:0]           acc_w_r   [2];
	logic [31:0]           acc_w_nxt [2];
	rmxu_pkg::rmxu_cmd_s   cmd_r;
	rmxu_pkg::rmxu_cmd_s   cmd_nxt;
	rmxu_pkg::rmxu_flags_s flags_r;
	rmxu_pkg::rmxu_flags_s flags_nxt;
	logic                  ack_r;
	logic                  ack_nxt;
	logic [31:0]           dat_r;
	logic [31:0]           dat_nxt;

	// Combinational helpers.
	logic                  take;
	logic                  gpr_hit;
	logic [3:0]            gpr_idx;
	logic [31:0]           wr_word;
	rmxu_pkg::rmxu_cmd_s   c;
	logic [2:0]            dd;
	logic [2:0]            ds;
	logic [31:0]           sv;
	logic [31:0]           res32;
	logic [16:0]           x_lo;
	logic [16:0]           x_hi;
	logic                  sgn;

	////////////////////////////////////////////////////////////////////////
	// Bus decode and operation execution.

	// A request is taken once per bus cycle; ack then stands one cycle.
	always_comb
	begin
		gpr_nxt   = gpr_r;
		acc_x_nxt = acc_x_r;
		acc_w_nxt = acc_w_r;
		cmd_nxt   = cmd_r;
		flags_nxt = flags_r;
		take      = wb_cyc_i & wb_stb_i & ~ack_r;
		ack_nxt   = take;
		dat_nxt   = 32'h0000_0000;
		gpr_hit   = (wb_adr_i[7:6] == rmxu_pkg::RMXU_GPR_PAGE);
		gpr_idx   = wb_adr_i[5:2];
		wr_word   = 32'h0000_0000;
		c         = cmd_r;
		dd        = cmd_r.dst[2:0];
		ds        = cmd_r.src[2:0];
		sv        = 32'h0000_0000;
		res32     = 32'h0000_0000;
		x_lo      = 17'h0_0000;
		x_hi      = 17'h0_0000;
		sgn       = 1'b0;

		// Reads: unmapped words answer zero.
		if (take && !wb_we_i)
		begin
			if (gpr_hit)
			begin
				dat_nxt = gpr_r[gpr_idx];
			end
			else
			begin
				unique case (wb_adr_i)
					rmxu_pkg::RMXU_ADR_CMD:    dat_nxt = {16'h0000, cmd_r};
					rmxu_pkg::RMXU_ADR_STATUS: dat_nxt = {25'h0, flags_r};
					rmxu_pkg::RMXU_ADR_A0X:    dat_nxt = {24'h0, acc_x_r[0]};
					rmxu_pkg::RMXU_ADR_A0W:    dat_nxt = acc_w_r[0];
					rmxu_pkg::RMXU_ADR_A1X:    dat_nxt = {24'h0, acc_x_r[1]};
					rmxu_pkg::RMXU_ADR_A1W:    dat_nxt = acc_w_r[1];
					default:                   dat_nxt = 32'h0000_0000;
				endcase
			end
		end

		// Plain register writes; unmapped writes are dropped.
		if (take && wb_we_i)
		begin
			if (gpr_hit)
			begin
				gpr_nxt[gpr_idx] = rmxu_merge(gpr_r[gpr_idx], wb_dat_i, wb_sel_i);
			end
			else
			begin
				unique case (wb_adr_i)
					rmxu_pkg::RMXU_ADR_STATUS:
					begin
						wr_word   = rmxu_merge({25'h0, flags_r}, wb_dat_i, wb_sel_i);
						flags_nxt = rmxu_pkg::rmxu_flags_s'(wr_word[6:0]);
					end
					rmxu_pkg::RMXU_ADR_A0X:
					begin
						wr_word      = rmxu_merge({24'h0, acc_x_r[0]}, wb_dat_i, wb_sel_i);
						acc_x_nxt[0] = wr_word[7:0];
					end
					rmxu_pkg::RMXU_ADR_A0W:
					begin
						acc_w_nxt[0] = rmxu_merge(acc_w_r[0], wb_dat_i, wb_sel_i);
					end
					rmxu_pkg::RMXU_ADR_A1X:
					begin
						wr_word      = rmxu_merge({24'h0, acc_x_r[1]}, wb_dat_i, wb_sel_i);
						acc_x_nxt[1] = wr_word[7:0];
					end
					rmxu_pkg::RMXU_ADR_A1W:
					begin
						acc_w_nxt[1] = rmxu_merge(acc_w_r[1], wb_dat_i, wb_sel_i);
					end
					default:
					begin
						wr_word = 32'h0000_0000;
					end
				endcase
			end
		end

		// A write of the command register runs the operation at once.
		if (take && wb_we_i && !gpr_hit && wb_adr_i == rmxu_pkg::RMXU_ADR_CMD)
		begin
			wr_word = rmxu_merge({16'h0000, cmd_r}, wb_dat_i, wb_sel_i);
			c       = rmxu_pkg::rmxu_cmd_s'(wr_word[15:0]);
			cmd_nxt = c;
			dd      = c.dst[2:0];
			ds      = c.src[2:0];
			sv      = gpr_r[ds];
			unique case (c.op)
				// Conditional moves see all sixteen registers; flags stay.
				rmxu_pkg::RMXU_OP_MOV_SET:
				begin
					if (flags_r.condition_flag)
					begin
						gpr_nxt[c.dst] = gpr_r[c.src];
					end
				end
				rmxu_pkg::RMXU_OP_MOV_CLR:
				begin
					if (!flags_r.condition_flag)
					begin
						gpr_nxt[c.dst] = gpr_r[c.src];
					end
				end
				rmxu_pkg::RMXU_OP_ZEXT, rmxu_pkg::RMXU_OP_SEXT:
				begin
					sgn   = (c.op == rmxu_pkg::RMXU_OP_SEXT) & sv[15];
					res32 = {{16{sgn}}, sv[15:0]};
					gpr_nxt[dd]             = res32;
					flags_nxt.zero_flag     = (res32 == 32'h0000_0000);
					flags_nxt.negative_flag = res32[31];
					flags_nxt.carry_flag    = 1'b0;
					flags_nxt.overflow_flag = 1'b0;
				end
				rmxu_pkg::RMXU_OP_EXT_WR:
				begin
					acc_x_nxt[c.acc_sel] = sv[7:0];
				end
				rmxu_pkg::RMXU_OP_EXT_RD:
				begin
					gpr_nxt[dd][15:0] = {{8{acc_x_r[c.acc_sel][7]}},
						acc_x_r[c.acc_sel]};
				end
				rmxu_pkg::RMXU_OP_ACC_LO:
				begin
					acc_w_nxt[c.acc_sel][15:0] = sv[15:0];
				end
				rmxu_pkg::RMXU_OP_ACC_HI:
				begin
					acc_w_nxt[c.acc_sel][31:16] = sv[31:16];
				end
				rmxu_pkg::RMXU_OP_XTR_LO, rmxu_pkg::RMXU_OP_XTR_HI,
				rmxu_pkg::RMXU_OP_XTR_BOTH:
				begin
					// One destination field serves both halves of a pair.
					x_lo = rmxu_extract({acc_x_r[0], acc_w_r[0]}, c.fmt,
						flags_r.rounding_select_bit);
					x_hi = rmxu_extract({acc_x_r[1], acc_w_r[1]}, c.fmt,
						flags_r.rounding_select_bit);
					sgn  = (c.fmt != rmxu_pkg::RMXU_FMT_UFRAC)
						&& (c.fmt != rmxu_pkg::RMXU_FMT_UINT);
					if (c.op == rmxu_pkg::RMXU_OP_XTR_LO)
					begin
						x_hi = 17'h0_0001;
						x_hi[16] = 1'b0;
						gpr_nxt[dd][15:0] = x_lo[15:0];
					end
					else if (c.op == rmxu_pkg::RMXU_OP_XTR_HI)
					begin
						x_lo = 17'h0_0001;
						x_lo[16] = 1'b0;
						gpr_nxt[dd][31:16] = x_hi[15:0];
					end
					else
					begin
						gpr_nxt[dd] = {x_hi[15:0], x_lo[15:0]};
					end
					// An unused half is forced nonzero and positive so that
					// the OR of the two flag sets reflects the live half.
					flags_nxt.zero_flag     = (x_lo[15:0] == 16'h0000)
						| (x_hi[15:0] == 16'h0000);
					flags_nxt.negative_flag = sgn & (x_lo[15] | x_hi[15]);
					flags_nxt.overflow_flag = x_lo[16] | x_hi[16];
					flags_nxt.sticky_overflow_flag = flags_r.sticky_overflow_flag
						| x_lo[16] | x_hi[16];
				end
				default:
				begin
					sv = 32'h0000_0000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers.

	// Synchronous reset brings every register to a known constant.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < 16; i++)
			begin
				gpr_r[i] <= rmxu_pkg::RMXU_RST_WORD;
			end
			for (int j = 0; j < 2; j++)
			begin
				acc_x_r[j] <= rmxu_pkg::RMXU_RST_EXT;
				acc_w_r[j] <= rmxu_pkg::RMXU_RST_WORD;
			end
			cmd_r   <= rmxu_pkg::rmxu_cmd_s'(rmxu_pkg::RMXU_RST_CMD);
			flags_r <= rmxu_pkg::rmxu_flags_s'(rmxu_pkg::RMXU_RST_FLAGS);
			ack_r   <= 1'b0;
			dat_r   <= rmxu_pkg::RMXU_RST_WORD;
		end
		else
		begin
			gpr_r   <= gpr_nxt;
			acc_x_r <= acc_x_nxt;
			acc_w_r <= acc_w_nxt;
			cmd_r   <= cmd_nxt;
			flags_r <= flags_nxt;
			ack_r   <= ack_nxt;
			dat_r   <= dat_nxt;
		end
	end

	// Bus outputs come straight from flip-flops.
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

endmodule : rmxu_top

/* bench/rmxu_top_asserts.sv */
/*
 * Bus port checker of the register move unit.
 * Assumes it is bound to rmxu_top and shares its single clock.
 */
`timescale 1ns/1ps

module rmxu_top_asserts (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o
);
	logic       take;
	logic [7:0] adr_nxt;
	logic [7:0] adr_r;
	logic       rd_nxt;
	logic       rd_r;

	////////////////////////////////////////////////////////////////
	// Remember each taken request so its answer can be judged by address.
	always_comb
	begin
		take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
		adr_nxt = take ? wb_adr_i : adr_r;
		rd_nxt  = take && !wb_we_i;
	end

	// No reset: these are only looked at while ack is high.
	always_ff @(posedge clk)
	begin
		adr_r <= adr_nxt;
		rd_r  <= rd_nxt;
	end

	////////////////////////////////////////////////////////////////
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// Handshake: one answer per request, one cycle later, one cycle long.
	a_ack_after_take: assert property (take |=> wb_ack_o)
		else $error("request not answered");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_no_idle_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");

	// Read data is zero outside the answer of a read.
	a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("data outside ack");
	a_write_data_zero: assert property (wb_ack_o && !rd_r |-> wb_dat_o == 32'h0)
		else $error("data on write answer");

	// Narrow registers read back with zero upper bits.
	a_ext_byte_only: assert property (wb_ack_o && rd_r && (adr_r == rmxu_pkg::RMXU_ADR_A0X ||
		adr_r == rmxu_pkg::RMXU_ADR_A1X) |-> wb_dat_o[31:8] == 24'h0)
		else $error("extension wider than a byte");
	a_status_width: assert property (wb_ack_o && rd_r && adr_r == rmxu_pkg::RMXU_ADR_STATUS
		|-> wb_dat_o[31:7] == 25'h0)
		else $error("status wider than seven bits");
	a_unmapped_zero: assert property (wb_ack_o && rd_r && adr_r[7:6] == 2'h0
		&& adr_r >= 8'h18 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");

	c_read: cover property (wb_ack_o && rd_r);
	c_write: cover property (wb_ack_o && !rd_r);
	c_gpr_read: cover property (wb_ack_o && rd_r && adr_r[7:6] == 2'h1);

endmodule : rmxu_top_asserts

/* bench/test_register_move_extend_unit.sv */
/*
 * Self-checking bench of the register move unit, driven through its bus.
 * Assumes rmxu_pkg, rmxu_top and the checker are compiled first.
 */
`timescale 1ns/1ps

module test_register_move_extend_unit;
	localparam logic [7:0] adr_st  = rmxu_pkg::RMXU_ADR_STATUS;
	localparam logic [7:0] adr_a0x = rmxu_pkg::RMXU_ADR_A0X;
	localparam logic [7:0] adr_a0w = rmxu_pkg::RMXU_ADR_A0W;
	localparam logic [7:0] adr_a1x = rmxu_pkg::RMXU_ADR_A1X;
	localparam logic [7:0] adr_a1w = rmxu_pkg::RMXU_ADR_A1W;
	logic        clk;
	logic        reset_n;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	int          err_count;
	int          check_count;
	int          cycles;

	rmxu_top dut (
		.clk      (clk),
		.reset_n  (reset_n),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_we_i  (wb_we_i),
		.wb_adr_i (wb_adr_i),
		.wb_sel_i (wb_sel_i),
		.wb_dat_i (wb_dat_i),
		.wb_dat_o (wb_dat_o),
		.wb_ack_o (wb_ack_o)
	);

	////////////////////////////////////////////////////////////////
	// Clock of 4 ns period.
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// A hung handshake would stall forever, so the run is capped.
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			err_count++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One classic cycle; the request is held until ack is sampled.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
			@(posedge clk);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, e);
	endtask : rd

	task automatic cmd(input logic [3:0] o, input logic [3:0] t, input logic [3:0] s,
		input logic c, input logic [2:0] f);
		wr(rmxu_pkg::RMXU_ADR_CMD, {16'h0, f, c, s, t, o});
	endtask : cmd

	////////////////////////////////////////////////////////////////
	// Conditional moves between data and pointer registers, both flag states.
	task automatic t_cond();
		wr(8'h40, 32'h1234_5678);
		wr(adr_st, 32'h1d);
		cmd(4'h1, 4'hf, 4'h0, 1'b0, 3'h0);
		rd(8'h7c, 32'h1234_5678);
		cmd(4'h2, 4'h9, 4'hf, 1'b0, 3'h0);
		rd(8'h64, 32'h0);
		rd(adr_st, 32'h1d);
		wr(adr_st, 32'h1c);
		cmd(4'h1, 4'h8, 4'h0, 1'b0, 3'h0);
		rd(8'h60, 32'h0);
		cmd(4'h2, 4'h9, 4'hf, 1'b0, 3'h0);
		rd(8'h64, 32'h1234_5678);
		rd(adr_st, 32'h1c);
	endtask : t_cond

	// Half to word extension with stale flags preset.
	task automatic t_ext16();
		wr(8'h44, 32'h1234_8000);
		wr(adr_st, 32'h5c);
		cmd(4'h3, 4'h2, 4'h1, 1'b0, 3'h0);
		rd(8'h48, 32'h0000_8000);
		rd(adr_st, 32'h40);
		wr(adr_st, 32'h5a);
		cmd(4'h4, 4'h3, 4'h1, 1'b0, 3'h0);
		rd(8'h4c, 32'hffff_8000);
		rd(adr_st, 32'h44);
		wr(8'h44, 32'h1234_0000);
		cmd(4'h3, 4'h2, 4'h1, 1'b0, 3'h0);
		rd(8'h48, 32'h0);
		rd(adr_st, 32'h42);
	endtask : t_ext16

	// Extension bytes, accumulator halves and an unmapped address.
	task automatic t_half();
		wr(8'h44, 32'h0000_1f80);
		cmd(4'h5, 4'h0, 4'h1, 1'b0, 3'h0);
		rd(adr_a0x, 32'h80);
		wr(8'h50, 32'haaaa_5555);
		cmd(4'h6, 4'h4, 4'h0, 1'b0, 3'h0);
		rd(8'h50, 32'haaaa_ff80);
		wr(adr_a0w, 32'h1111_2222);
		wr(8'h54, 32'habcd_ef01);
		cmd(4'h7, 4'h0, 4'h5, 1'b0, 3'h0);
		rd(adr_a0w, 32'h1111_ef01);
		cmd(4'h8, 4'h0, 4'h5, 1'b1, 3'h0);
		rd(adr_a1w, 32'habcd_0000);
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20, 32'h0);
	endtask : t_half

	// Every format, both rounding modes, on a value exactly at the half.
	task automatic t_xtr();
		logic [15:0] res [8] = '{16'h1234, 16'h1234, 16'h7fff, 16'hffff,
			16'h1234, 16'h2469, 16'h7fff, 16'h1234};
		logic [15:0] e;
		logic        v;
		wr(adr_a0x, 32'h0);
		wr(adr_a0w, 32'h1234_8000);
		wr(8'h58, 32'h5a5a_0000);
		for (int r = 0; r < 2; r++)
		begin
			for (int f = 0; f < 8; f++)
			begin
				e = res[f] + 16'(r == 1 && (f < 2 || f == 7));
				v = (f == 2 || f == 3 || f == 6);
				wr(adr_st, 32'(r) << 6);
				cmd(4'h9, 4'h6, 4'h0, 1'b0, 3'(f));
				rd(8'h58, {16'h5a5a, e});
				rd(adr_st, {25'h0, 1'(r), v, v, 4'h0});
			end
		end
		rd(adr_a0w, 32'h1234_8000);
		rd(adr_a0x, 32'h0);
	endtask : t_xtr

	// Rounding that overflows, sticky overflow, plain integer pickup.
	task automatic t_round();
		wr(adr_a0w, 32'h7fff_8000);
		wr(adr_st, 32'h40);
		cmd(4'h9, 4'h6, 4'h0, 1'b0, 3'h0);
		rd(8'h58, 32'h5a5a_7fff);
		rd(adr_st, 32'h70);
		cmd(4'h9, 4'h6, 4'h0, 1'b0, 3'h4);
		rd(adr_st, 32'h60);
		wr(adr_a0w, 32'h0000_1234);
		cmd(4'h9, 4'h6, 4'h0, 1'b0, 3'h2);
		rd(8'h58, 32'h5a5a_1234);
	endtask : t_round

	// Both accumulators into one register, one half saturating low; then the
	// high half alone, which must leave the low half and sticky overflow be.
	task automatic t_dual();
		wr(adr_a0w, 32'h1234_8000);
		wr(adr_a1x, 32'h80);
		wr(adr_a1w, 32'h0);
		wr(adr_st, 32'h40);
		cmd(4'hb, 4'h7, 4'h0, 1'b0, 3'h0);
		rd(8'h5c, 32'h8000_1235);
		rd(adr_st, 32'h74);
		wr(adr_a1x, 32'h0);
		wr(adr_a1w, 32'h0042_0000);
		cmd(4'ha, 4'h7, 4'h0, 1'b0, 3'h0);
		rd(8'h5c, 32'h0042_1235);
		rd(adr_st, 32'h60);
	endtask : t_dual

	////////////////////////////////////////////////////////////////
	// Reset, reset values, then the scenarios in order.
	initial
	begin
		reset_n     = 1'b0;
		wb_cyc_i    = 1'b0;
		wb_stb_i    = 1'b0;
		wb_we_i     = 1'b0;
		wb_adr_i    = 8'h0;
		wb_sel_i    = 4'hf;
		wb_dat_i    = 32'h0;
		err_count   = 0;
		check_count = 0;
		cycles      = 0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		rd(adr_st, 32'h0);
		rd(adr_a0w, 32'h0);
		t_cond();
		t_ext16();
		t_half();
		t_xtr();
		t_round();
		t_dual();
		end_sim();
	end

endmodule : test_register_move_extend_unit

bind rmxu_top rmxu_top_asserts u_chk (
	.clk      (clk),
	.reset_n  (reset_n),
	.wb_cyc_i (wb_cyc_i),
	.wb_stb_i (wb_stb_i),
	.wb_we_i  (wb_we_i),
	.wb_adr_i (wb_adr_i),
	.wb_dat_o (wb_dat_o),
	.wb_ack_o (wb_ack_o)
);
